/* verilog/ipa_indirect_ptr2.sv */
// pointer pair two with its five virtual access registers
`timescale 1ns/10ps
module ipa_indirect_ptr2 import ipa_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core indirect request
	input wire logic idxValid,
	input wire logic idxWrite,
	input wire ipa_sel_t idxSel,
	input wire logic [DATA_W-1:0] idxWreg,
	input wire logic [DATA_W-1:0] idxWdata,
	output logic idxDone,
	output logic [DATA_W-1:0] idxRdata,
	// core direct access to the pointer bytes
	input wire logic dirValid,
	input wire logic dirWrite,
	input wire logic [ADDR_W-1:0] dirAddr,
	input wire logic [DATA_W-1:0] dirWdata,
	output logic dirHit,
	output logic [DATA_W-1:0] dirRdata,
	// data memory
	output logic memReq,
	output logic memWe,
	output logic [ADDR_W-1:0] memAddr,
	output logic [DATA_W-1:0] memWdata,
	input wire logic [DATA_W-1:0] memRdata
);
	logic [ADDR_W-1:0] ptr_q, ptr_d;
	logic [ADDR_W-1:0] effAddr, nextPtr;
	logic wrHigh, wrLow;
	logic [DATA_W-1:0] apbData;
	logic tgtVirt, tgtHigh, tgtLow, tgtSelf;

	logic memReq_q, memReq_d, memWe_q, memWe_d;
	logic [ADDR_W-1:0] memAddr_q, memAddr_d;
	logic [DATA_W-1:0] memWdata_q, memWdata_d;
	logic s1Valid_q, s1Valid_d, s1Zero_q, s1Zero_d, s1Self_q, s1Self_d;
	logic [DATA_W-1:0] s1Data_q, s1Data_d;
	logic done_q, done_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic dirHit_q, dirHit_d;
	logic [DATA_W-1:0] dirRdata_q, dirRdata_d;

	ipa_addr_gen u_gen (
		.ptr(ptr_q),
		.sel(idxSel),
		.wreg(idxWreg),
		.effAddr(effAddr),
		.nextPtr(nextPtr)
	);

	ipa_apb_slave u_apb (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.highVal(highByte(ptr_q)),
		.lowVal(ptr_q[DATA_W-1:0]),
		.wrHigh(wrHigh),
		.wrLow(wrLow),
		.wrData(apbData)
	);

	assign tgtVirt = isAnyVirt(effAddr);
	assign tgtHigh = (effAddr == PTR2_HIGH_SFR);
	assign tgtLow = (effAddr == PTR2_LOW_SFR);
	assign tgtSelf = tgtHigh | tgtLow;

	// pointer: bus first, then direct, then indirect; the core wins a tie
	always_comb begin
		ptr_d = ptr_q;
		if (wrHigh) begin
			ptr_d[ADDR_W-1:DATA_W] = apbData[HIGH_W-1:0]; // R06
		end
		if (wrLow) begin
			ptr_d[DATA_W-1:0] = apbData; // R07
		end
		if (dirValid & dirWrite & (dirAddr == PTR2_HIGH_SFR)) begin
			ptr_d[ADDR_W-1:DATA_W] = dirWdata[HIGH_W-1:0]; // R11
		end else if (dirValid & dirWrite & (dirAddr == PTR2_LOW_SFR)) begin
			ptr_d[DATA_W-1:0] = dirWdata; // R11
		end
		if (idxValid) begin
			if (idxWrite & tgtHigh) begin
				ptr_d = {idxWdata[HIGH_W-1:0], ptr_q[DATA_W-1:0]}; // R10
			end else if (idxWrite & tgtLow) begin
				ptr_d = {ptr_q[ADDR_W-1:DATA_W], idxWdata}; // R10
			// non-stepping access must not undo a bus or direct write
			end else if (nextPtr != ptr_q) begin
				ptr_d = nextPtr; // R14
			end
		end
	end

	// request stage: virtual targets never reach memory
	always_comb begin
		s1Valid_d = idxValid;
		s1Zero_d = idxValid & tgtVirt; // R08
		s1Self_d = idxValid & tgtSelf;
		s1Data_d = tgtHigh ? highByte(ptr_q) : ptr_q[DATA_W-1:0];
		memReq_d = idxValid & ~tgtVirt & ~tgtSelf; // R09 R12
		memWe_d = idxValid & idxWrite & ~tgtVirt & ~tgtSelf; // R09
		memAddr_d = memReq_d ? effAddr : memAddr_q;
		memWdata_d = memReq_d ? idxWdata : memWdata_q;
	end

	// answer stage: memory data is read in the cycle memReq is high
	always_comb begin
		done_d = s1Valid_q;
		rdata_d = rdata_q;
		if (s1Valid_q) begin
			if (s1Zero_q) begin
				rdata_d = 8'h00; // R08
			end else if (s1Self_q) begin
				rdata_d = s1Data_q;
			end else begin
				rdata_d = memRdata; // R12
			end
		end
	end

	always_comb begin
		dirHit_d = dirValid & ((dirAddr == PTR2_HIGH_SFR) |
			(dirAddr == PTR2_LOW_SFR));
		dirRdata_d = dirRdata_q;
		if (dirValid & (dirAddr == PTR2_HIGH_SFR)) begin
			dirRdata_d = highByte(ptr_q); // R06 R11
		end else if (dirValid & (dirAddr == PTR2_LOW_SFR)) begin
			dirRdata_d = ptr_q[DATA_W-1:0]; // R11
		end
	end

	// low byte resets to a known value although software may not rely on it
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ptr_q <= PTR_RESET; // R06 R07
			memReq_q <= 1'b0;
			memWe_q <= 1'b0;
			memAddr_q <= PTR_RESET;
			memWdata_q <= 8'h00;
			s1Valid_q <= 1'b0;
			s1Zero_q <= 1'b0;
			s1Self_q <= 1'b0;
			s1Data_q <= 8'h00;
			done_q <= 1'b0;
			rdata_q <= 8'h00;
			dirHit_q <= 1'b0;
			dirRdata_q <= 8'h00;
		end else begin
			ptr_q <= ptr_d;
			memReq_q <= memReq_d;
			memWe_q <= memWe_d;
			memAddr_q <= memAddr_d;
			memWdata_q <= memWdata_d;
			s1Valid_q <= s1Valid_d;
			s1Zero_q <= s1Zero_d;
			s1Self_q <= s1Self_d;
			s1Data_q <= s1Data_d;
			done_q <= done_d;
			rdata_q <= rdata_d;
			dirHit_q <= dirHit_d;
			dirRdata_q <= dirRdata_d;
		end
	end

	assign memReq = memReq_q;
	assign memWe = memWe_q;
	assign memAddr = memAddr_q;
	assign memWdata = memWdata_q;
	assign idxDone = done_q;
	assign idxRdata = rdata_q;
	assign dirHit = dirHit_q;
	assign dirRdata = dirRdata_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	logic quiet;
	assign quiet = ~wrHigh & ~wrLow & ~dirValid;

	plain_keep_a: assert property (idxValid & quiet & ~tgtSelf & // R01
		(idxSel == PTR2_PLAIN_ACCESS) |=> $stable(ptr_q))
		else $error("plain access moved the pointer");
	post_inc_a: assert property (idxValid & quiet & ~(idxWrite & tgtSelf) & // R02
		(idxSel == PTR2_ACCESS_THEN_INC) |=>
		ptr_q == $past(ptr_q) + PTR_STEP)
		else $error("post-increment step wrong");
	post_dec_a: assert property (idxValid & quiet & ~(idxWrite & tgtSelf) & // R03
		(idxSel == PTR2_ACCESS_THEN_DEC) |=>
		ptr_q == $past(ptr_q) - PTR_STEP)
		else $error("post-decrement step wrong");
	pre_inc_addr_a: assert property (idxValid & ~tgtVirt & ~tgtSelf & // R04
		(idxSel == PTR2_INC_THEN_ACCESS) |=>
		memReq_q && memAddr_q == $past(ptr_q) + PTR_STEP)
		else $error("pre-increment address wrong");
	offset_addr_a: assert property (idxValid & ~tgtVirt & ~tgtSelf & // R05
		(idxSel == PTR2_OFFSET_BY_ACCUM) |=> memReq_q &&
		memAddr_q == $past(ptr_q) + {{4{$past(idxWreg[7])}}, $past(idxWreg)})
		else $error("offset address wrong");
	high_zero_a: assert property (dirValid & (dirAddr == PTR2_HIGH_SFR) // R06
		|=> dirRdata_q[7:4] == 4'h0)
		else $error("high byte upper bits not zero");
	virt_read_a: assert property (idxValid & ~idxWrite & tgtVirt // R08
		|=> ##1 idxDone && idxRdata == 8'h00)
		else $error("virtual read did not return zero");
	virt_write_a: assert property (idxValid & idxWrite & tgtVirt // R09
		|=> !memReq_q && !memWe_q)
		else $error("virtual write reached memory");
	self_write_a: assert property (idxValid & idxWrite & tgtLow // R10
		|=> ptr_q[7:0] == $past(idxWdata) &&
		ptr_q[11:8] == $past(ptr_q[11:8]))
		else $error("self write stepped the pointer");
	one_update_a: assert property (idxValid & quiet & ~idxWrite & // R14
		~tgtSelf |=> ptr_q == $past(nextPtr))
		else $error("pointer update missing");

	idx_done_a: assert property (idxValid |=> ##1 idxDone) // R14
		else $error("indirect answer not on time");

	mem_we_a: assert property (memWe_q |-> memReq_q) // R09
		else $error("write strobe without request");

	self_noreq_a: assert property (idxValid & tgtSelf // R10
		|=> !memReq_q)
		else $error("pointer byte access reached memory");

	self_high_a: assert property (idxValid & idxWrite & tgtHigh // R10
		|=> ptr_q[11:8] == $past(idxWdata[3:0]) &&
		ptr_q[7:0] == $past(ptr_q[7:0]))
		else $error("self write to high byte wrong");

	pre_inc_step_a: assert property (idxValid & quiet & // R04
		~(idxWrite & tgtSelf) & (idxSel == PTR2_INC_THEN_ACCESS)
		|=> ptr_q == $past(ptr_q) + PTR_STEP)
		else $error("pre-increment step wrong");

	offset_keep_a: assert property (idxValid & quiet & // R05
		~(idxWrite & tgtSelf) & (idxSel == PTR2_OFFSET_BY_ACCUM)
		|=> $stable(ptr_q))
		else $error("offset access moved the pointer");

	access_addr_a: assert property (idxValid & ~tgtVirt & // R02
		~tgtSelf & (idxSel == PTR2_PLAIN_ACCESS ||
		idxSel == PTR2_ACCESS_THEN_INC ||
		idxSel == PTR2_ACCESS_THEN_DEC)
		|=> memReq_q && memAddr_q == $past(ptr_q))
		else $error("access address not the old pointer");

	virt_noreq_a: assert property (idxValid & ~idxWrite & tgtVirt // R08
		|=> !memReq_q)
		else $error("virtual read reached memory");

	mem_read_a: assert property (idxValid & ~idxWrite & ~tgtVirt & // R12
		~tgtSelf |=> ##1 idxDone && idxRdata == $past(memRdata))
		else $error("memory read data not returned");

	self_read_a: assert property (idxValid & ~idxWrite & tgtLow // R11
		|=> ##1 idxRdata == $past(ptr_q[7:0], 2))
		else $error("pointer byte read wrong");

	dir_low_a: assert property (dirValid & dirWrite & ~idxValid & // R11
		(dirAddr == PTR2_LOW_SFR) |=> ptr_q[7:0] == $past(dirWdata))
		else $error("direct low byte write lost");

	dir_read_a: assert property (dirValid & // R11
		(dirAddr == PTR2_LOW_SFR) |=>
		dirHit && dirRdata == $past(ptr_q[7:0]))
		else $error("direct low byte read wrong");

	dir_hit_a: assert property (dirValid & // R11
		(dirAddr == PTR2_HIGH_SFR) |=> dirHit)
		else $error("direct high byte not hit");

	apb_low_a: assert property (wrLow & ~idxValid & ~dirValid // R07
		|=> ptr_q[7:0] == $past(apbData))
		else $error("bus write to low byte lost");

	apb_pulse_a: assert property (pready |=> !pready) // R11
		else $error("ready held beyond one cycle");

	err_ready_a: assert property (pslverr |-> pready) // R11
		else $error("error flag without ready");

	dec_wrap_a: assert property (idxValid & quiet & ~idxWrite & // R13
		(idxSel == PTR2_ACCESS_THEN_DEC) & (ptr_q == PTR_RESET)
		|=> ptr_q == PTR_RESET - PTR_STEP)
		else $error("pointer did not wrap on borrow");

	cov_postinc_c: cover property (idxValid &&
		idxSel == PTR2_ACCESS_THEN_INC ##1 idxValid);
	cov_virt_c: cover property (idxValid && tgtVirt);
	cov_self_c: cover property (idxValid && idxWrite && tgtSelf);
	cov_apb_c: cover property (wrHigh || wrLow);
	cov_dir_c: cover property (dirValid && dirWrite);
endmodule

/* inc/ipa_pkg.sv */
// constants, types and helpers for the pointer pair two indirect access block
// Notes on behaviour
// (R01) plain access uses pointer, pointer unchanged
// (R02) post-increment: access at pointer, then add one
// (R03) post-decrement: access at pointer, then subtract one
// (R04) pre-increment: add one, then access there
// (R05) offset access: pointer plus working register
// (R06) high register: four bits, reset zero
// (R07) low register: eight bits, reset unknown
// (R08) indirect read of virtual register returns zero
// (R09) indirect write to virtual register does nothing
// (R10) self write stores value, no pointer step
// (R11) pointer bytes reachable by direct access
// (R12) indirect access reaches other registers normally
// (R13) twelve-bit pointer, carry across both bytes
// (R14) one pointer update per access, same cycle
package ipa_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int HIGH_W = 4;
	localparam int APB_AW = 12;

	typedef enum logic [2:0] {
		PTR2_PLAIN_ACCESS = 3'b000,
		PTR2_ACCESS_THEN_INC = 3'b001,
		PTR2_ACCESS_THEN_DEC = 3'b010,
		PTR2_INC_THEN_ACCESS = 3'b011,
		PTR2_OFFSET_BY_ACCUM = 3'b100
	} ipa_sel_t;

	// data-space addresses; each virtual block spans top-4 .. top
	localparam logic [ADDR_W-1:0] PTR0_VIRT_TOP = 12'hFEF;
	localparam logic [ADDR_W-1:0] PTR1_VIRT_TOP = 12'hFE7;
	localparam logic [ADDR_W-1:0] PTR2_VIRT_TOP = 12'hFDF;
	localparam logic [ADDR_W-1:0] VIRT_SPAN = 12'h004;
	localparam logic [ADDR_W-1:0] PTR2_HIGH_SFR = 12'hFDA;
	localparam logic [ADDR_W-1:0] PTR2_LOW_SFR = 12'hFD9;

	// register bus byte offsets
	localparam logic [APB_AW-1:0] APB_HIGH_OFS = 12'h000;
	localparam logic [APB_AW-1:0] APB_LOW_OFS = 12'h004;

	localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
	localparam logic [ADDR_W-1:0] PTR_STEP = 12'h001;

	function automatic logic inVirt(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] top);
		return (a <= top) && (a >= top - VIRT_SPAN);
	endfunction

	function automatic logic isAnyVirt(input logic [ADDR_W-1:0] a);
		return inVirt(a, PTR0_VIRT_TOP) | inVirt(a, PTR1_VIRT_TOP) |
			inVirt(a, PTR2_VIRT_TOP);
	endfunction

	function automatic logic [DATA_W-1:0] highByte(
		input logic [ADDR_W-1:0] p);
		return {4'h0, p[ADDR_W-1:DATA_W]};
	endfunction
endpackage

/* verilog/ipa_addr_gen.sv */
// effective address and next pointer value for pointer pair two
`timescale 1ns/10ps
module ipa_addr_gen import ipa_pkg::*; (
	// current state
	input wire logic [ADDR_W-1:0] ptr,
	input wire ipa_sel_t sel,
	input wire logic [DATA_W-1:0] wreg,
	// results
	output logic [ADDR_W-1:0] effAddr,
	output logic [ADDR_W-1:0] nextPtr
);
	logic [ADDR_W-1:0] offset;

	// working register taken as a signed offset, so stacks can reach back
	assign offset = {{(ADDR_W-DATA_W){wreg[DATA_W-1]}}, wreg};

	always_comb begin
		effAddr = ptr;
		nextPtr = ptr;
		case (sel)
			PTR2_PLAIN_ACCESS: begin
				effAddr = ptr; // R01
			end
			PTR2_ACCESS_THEN_INC: begin
				nextPtr = ptr + PTR_STEP; // R02 R13
			end
			PTR2_ACCESS_THEN_DEC: begin
				nextPtr = ptr - PTR_STEP; // R03 R13
			end
			PTR2_INC_THEN_ACCESS: begin
				nextPtr = ptr + PTR_STEP; // R04 R13
				effAddr = ptr + PTR_STEP; // R04
			end
			PTR2_OFFSET_BY_ACCUM: begin
				effAddr = ptr + offset; // R05
			end
			default: begin
				effAddr = ptr;
			end
		endcase
	end
endmodule

/* verilog/ipa_apb_slave.sv */
// register bus slave for the two pointer bytes
`timescale 1ns/10ps
module ipa_apb_slave import ipa_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// register side
	input wire logic [DATA_W-1:0] highVal,
	input wire logic [DATA_W-1:0] lowVal,
	output logic wrHigh,
	output logic wrLow,
	output logic [DATA_W-1:0] wrData
);
	logic ready_q, ready_d;
	logic err_q, err_d;
	logic [31:0] rdata_q, rdata_d;
	logic hitHigh, hitLow, commit;

	always_comb begin
		hitHigh = 1'b0;
		hitLow = 1'b0;
		if (paddr == APB_HIGH_OFS) begin
			hitHigh = 1'b1;
		end else if (paddr == APB_LOW_OFS) begin
			hitLow = 1'b1;
		end
	end

	// one wait state: pready rises in the second access cycle
	assign commit = psel & penable & ready_q;
	assign wrHigh = commit & pwrite & hitHigh & ~err_q;
	assign wrLow = commit & pwrite & hitLow & ~err_q;
	assign wrData = pwdata[DATA_W-1:0];

	always_comb begin
		ready_d = 1'b0;
		err_d = 1'b0;
		rdata_d = 32'h0000_0000;
		if (psel & penable & ~ready_q) begin
			ready_d = 1'b1;
			err_d = ~(hitHigh | hitLow);
			if (~pwrite & hitHigh) begin
				rdata_d = {24'h00_0000, highVal}; // R06
			end else if (~pwrite & hitLow) begin
				rdata_d = {24'h00_0000, lowVal};
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ready_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ready_q <= ready_d;
			err_q <= err_d;
			rdata_q <= rdata_d;
		end
	end

	assign pready = ready_q;
	assign pslverr = err_q;
	assign prdata = rdata_q;
endmodule

/* tb/ipa_mem_model.sv */
// data memory model answering the pointer block's requests
`timescale 1ns/10ps
module ipa_mem_model import ipa_pkg::*; (
	// clock
	input wire logic core_clk,
	// request
	input wire logic memReq,
	input wire logic memWe,
	input wire logic [ADDR_W-1:0] memAddr,
	input wire logic [DATA_W-1:0] memWdata,
	// answer
	output logic [DATA_W-1:0] memRdata
);
	logic [DATA_W-1:0] mem [0:4095];
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem[i] = i[7:0] ^ 8'h3C;
		end
	end
	// off request the bus shows the inverse, so a stale sample never matches
	assign memRdata = memReq ? mem[memAddr] : ~mem[memAddr];
	always @(posedge core_clk) begin
		if (memReq && memWe) begin
			mem[memAddr] <= memWdata;
		end
	end
endmodule

/* tb/ipa_indirect_ptr2_test.sv */
// self-checking bench for the pointer pair two block
`timescale 1ns/10ps
module ipa_indirect_ptr2_test import ipa_pkg::*;;
	logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
	logic idxValid, idxWrite, idxDone, dirValid, dirWrite, dirHit;
	logic memReq, memWe;
	logic [11:0] paddr, dirAddr, memAddr;
	logic [31:0] pwdata, prdata;
	logic [7:0] idxWreg, idxWdata, idxRdata, dirWdata, dirRdata;
	logic [7:0] memRdata, memWdata;
	ipa_sel_t idxSel;
	int err_total, checks_done;
	ipa_indirect_ptr2 ipa_indirect_ptr2_i (.core_clk(core_clk),
		.rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .idxValid(idxValid), .idxWrite(idxWrite),
		.idxSel(idxSel), .idxWreg(idxWreg), .idxWdata(idxWdata),
		.idxDone(idxDone), .idxRdata(idxRdata), .dirValid(dirValid),
		.dirWrite(dirWrite), .dirAddr(dirAddr), .dirWdata(dirWdata),
		.dirHit(dirHit), .dirRdata(dirRdata), .memReq(memReq),
		.memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
		.memRdata(memRdata));
	ipa_mem_model ipa_mem_model_i (.core_clk(core_clk), .memReq(memReq),
		.memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
		.memRdata(memRdata));
	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	task final_report;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task hang;
		err_total++;
		$display("ERROR t=%0t no answer", $time);
		final_report;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		// wait is bounded; slave latency is not assumed
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) hang;
		r = prdata;
		e = pslverr;
		psel <= 0; penable <= 0;
	endtask
	task setptr(input logic [11:0] p);
		logic [31:0] r;
		logic e;
		apb(1, 12'h000, {28'h0, p[11:8]}, r, e);
		apb(1, 12'h004, {24'h0, p[7:0]}, r, e);
	endtask
	task getptr(output logic [11:0] p);
		logic [31:0] h, l;
		logic e;
		apb(0, 12'h000, 32'h0, h, e);
		apb(0, 12'h004, 32'h0, l, e);
		p = {h[3:0], l[7:0]};
	endtask
	task idx(input ipa_sel_t s, input logic w, input logic [7:0] wr, wd,
		output logic [11:0] a, output logic q, output logic [7:0] d);
		int n;
		q = 0; a = 12'h000; d = 8'h00; n = 0;
		@(posedge core_clk);
		idxValid <= 1; idxWrite <= w; idxSel <= s;
		idxWreg <= wr; idxWdata <= wd;
		@(posedge core_clk);
		idxValid <= 0;
		#1;
		while (idxDone !== 1'b1 && n < 5) begin
			if (memReq === 1'b1) begin
				q = 1;
				a = memAddr;
			end
			@(posedge core_clk);
			#1;
			n++;
		end
		if (n >= 5) hang;
		d = idxRdata;
	endtask
	task dir(input logic w, input logic [11:0] a, input logic [7:0] wd,
		output logic h, output logic [7:0] d);
		@(posedge core_clk);
		dirValid <= 1; dirWrite <= w; dirAddr <= a; dirWdata <= wd;
		@(posedge core_clk);
		dirValid <= 0;
		#1;
		h = dirHit;
		d = dirRdata;
	endtask
	task mode(input ipa_sel_t s, input logic [7:0] w,
		input logic [11:0] p0, ea, ep);
		logic [11:0] a, p;
		logic q;
		logic [7:0] d;
		setptr(p0);
		idx(s, 0, w, 8'h00, a, q, d);
		chk(32'(q), 32'h1);
		chk(32'(a), 32'(ea));
		chk(32'(d), 32'(ea[7:0] ^ 8'h3C));
		getptr(p);
		chk(32'(p), 32'(ep));
	endtask
	task t_reset;
		logic [11:0] p;
		logic [31:0] r;
		logic e;
		getptr(p);
		chk(32'(p), 32'h0);
		apb(1, 12'h000, 32'h000000FF, r, e);
		apb(0, 12'h000, 32'h0, r, e);
		chk(r, 32'h0000000F);
	endtask
	task t_write;
		logic [11:0] a;
		logic q;
		logic [7:0] d;
		setptr(12'h200);
		idx(PTR2_ACCESS_THEN_INC, 1, 8'h00, 8'h5A, a, q, d);
		chk(32'(a), 32'h200);
		setptr(12'h200);
		idx(PTR2_PLAIN_ACCESS, 0, 8'h00, 8'h00, a, q, d);
		chk(32'(d), 32'h5A);
	endtask
	task t_virt;
		logic [11:0] a, p;
		logic q;
		logic [7:0] d;
		setptr(12'hFE7);
		idx(PTR2_PLAIN_ACCESS, 0, 8'h00, 8'h00, a, q, d);
		chk(32'(q), 32'h0);
		chk(32'(d), 32'h0);
		idx(PTR2_PLAIN_ACCESS, 1, 8'h00, 8'h77, a, q, d);
		chk(32'(q), 32'h0);
		getptr(p);
		chk(32'(p), 32'hFE7);
	endtask
	task t_self;
		logic [11:0] a, p;
		logic q;
		logic [7:0] d;
		setptr(12'hFD9);
		idx(PTR2_ACCESS_THEN_DEC, 1, 8'h00, 8'h55, a, q, d);
		getptr(p);
		chk(32'(p), 32'hF55);
		setptr(12'hFDA);
		idx(PTR2_PLAIN_ACCESS, 1, 8'h00, 8'h03, a, q, d);
		getptr(p);
		chk(32'(p), 32'h3DA);
		setptr(12'hFD9);
		idx(PTR2_PLAIN_ACCESS, 0, 8'h00, 8'h00, a, q, d);
		chk(32'(q), 32'h0);
		chk(32'(d), 32'hD9);
	endtask
	task t_direct;
		logic h, e;
		logic [7:0] d;
		logic [31:0] r;
		dir(1, 12'hFD9, 8'h34, h, d);
		dir(0, 12'hFD9, 8'h00, h, d);
		chk(32'(h), 32'h1);
		chk(32'(d), 32'h34);
		dir(0, 12'h123, 8'h00, h, d);
		chk(32'(h), 32'h0);
		dir(0, 12'hFDA, 8'h00, h, d);
		chk(32'(h), 32'h1);
		chk(32'(d), 32'h0F);
		apb(1, 12'h008, 32'h000000AA, r, e);
		apb(0, 12'h008, 32'h0, r, e);
		chk(32'(e), 32'h1);
		chk(r, 32'h0);
	endtask
	initial begin
		err_total = 0; checks_done = 0;
		rst_b = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		idxValid = 0; idxWrite = 0; idxSel = PTR2_PLAIN_ACCESS;
		idxWreg = 0; idxWdata = 0;
		dirValid = 0; dirWrite = 0; dirAddr = 0; dirWdata = 0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1;
		t_reset;
		mode(PTR2_PLAIN_ACCESS, 0, 12'h0FF, 12'h0FF, 12'h0FF);
		mode(PTR2_ACCESS_THEN_INC, 0, 12'h0FF, 12'h0FF, 12'h100);
		mode(PTR2_ACCESS_THEN_DEC, 0, 12'h100, 12'h100, 12'h0FF);
		mode(PTR2_INC_THEN_ACCESS, 0, 12'h0FF, 12'h100, 12'h100);
		mode(PTR2_OFFSET_BY_ACCUM, 8'hFE, 12'h100, 12'h0FE, 12'h100);
		mode(PTR2_ACCESS_THEN_DEC, 0, 12'h000, 12'h000, 12'hFFF);
		t_write;
		t_virt;
		t_self;
		t_direct;
		final_report;
	end
endmodule
